// File: testbench/dacom_pin_ctl.sv
// Model of the outside controller that drives the two transmit-enable pins.
`timescale 1ns/1ns
module dacom_pin_ctl (
	input  wire logic clk,
	input  wire logic want_a,
	input  wire logic want_b,
	output logic      pin_a,
	output logic      pin_b
);
	// The pins are plain levels; the controller moves them one edge after it decides.
	always @(posedge clk) begin
		pin_a <= want_a;
		pin_b <= want_b;
	end
endmodule // dacom_pin_ctl

// File: testbench/tb_dacom_top.sv
// Self-checking bench for pulse format decode and transmit enable control.
`timescale 1ns/1ns
module tb_dacom_top
	import dacom_pkg::*;
;
	typedef struct packed {
		logic [7:0] wr;
		logic [6:0] ea;
		logic [6:0] eb;
	} dacom_row_t;

	logic              clk, rst_n, psel, penable, pwrite, valid, pready, pslverr;
	logic              want_a, want_b, pin_a, pin_b, clk_stop, datapath_enable, er;
	logic [11:0]       paddr;
	logic [31:0]       pwdata, prdata, rd;
	dacom_chan_t [1:0] ctl;
	int                failures, n_tests;
	logic [9:0]        ridx [4] = '{IDX_FORMAT, IDX_TRUNC, IDX_TXSEL, IDX_TXEN};
	logic [31:0]       rval [4] = '{32'h00, 32'h00, 32'h03, 32'h03};
	dacom_row_t        rows [10] = '{'{8'h10, 7'h40, 7'h20}, '{8'h21, 7'h20, 7'h10},
		'{8'h02, 7'h10, 7'h40}, '{8'h43, 7'h08, 7'h04}, '{8'h34, 7'h04, 7'h08},
		'{8'h55, 7'h02, 7'h02}, '{8'h56, 7'h01, 7'h02}, '{8'h65, 7'h02, 7'h01},
		'{8'h88, 7'h40, 7'h40}, '{8'h77, 7'h01, 7'h01}};

	dacom_top #(.ADDR_W(12), .QUIET_LAT(4)) dut (
		.REF_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'h1), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .CHAN_A_ENABLE_PIN(pin_a), .CHAN_B_ENABLE_PIN(pin_b),
		.OUT_DATA_VALID(valid), .CHAN_CTL(ctl), .CLK_STOP(clk_stop), .DP_ENABLE(datapath_enable));
	dacom_pin_ctl pins (.clk(clk), .want_a(want_a), .want_b(want_b), .pin_a(pin_a),
		.pin_b(pin_b));

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Entered just after a rising edge; holds the request until pready is sampled high.
	task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (n >= 40) failures++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		#100000;
		failures++;
		wrap_up();
	end

	initial begin
		failures = 0;
		n_tests = 0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		want_a = 1'b1;
		want_b = 1'b1;
		valid = 1'b0;
		cyc(20);
		chk(ctl, 32'h0);
		chk(clk_stop, 1'b0);
		rst_n <= 1'b1;
		cyc(3);
		chk(ctl[0].tx_on, 1'b1);
		chk(ctl[1].tx_on, 1'b1);
		chk(ctl[0].nrz, 1'b1);
		foreach (ridx[i]) begin
			apb(1'b0, ridx[i], 8'h00);
			chk(rd, rval[i]);
		end
		$display("test reset done");
		foreach (rows[i]) begin
			apb(1'b1, IDX_FORMAT, rows[i].wr);
			apb(1'b0, IDX_FORMAT, 8'h00);
			chk(rd, {24'h0, rows[i].wr});
			chk(ctl[0][10:4], rows[i].ea);
			chk(ctl[1][10:4], rows[i].eb);
		end
		$display("test formats done");
		chk(datapath_enable, 1'b0);
		apb(1'b1, IDX_TRUNC, 8'h01);
		cyc(2);
		chk(ctl[0].half_lsb, 1'b0);
		apb(1'b1, IDX_CTRL, 8'h02);
		cyc(2);
		chk(ctl[0].half_lsb, 1'b1);
		chk(ctl[1].half_lsb, 1'b1);
		apb(1'b1, IDX_TRUNC, 8'h00);
		cyc(2);
		chk(ctl[1].half_lsb, 1'b0);
		apb(1'b1, IDX_CTRL, 8'h00);
		$display("test truncation done");
		apb(1'b0, 10'h000, 8'h00);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		apb(1'b0, IDX_TXEN, 8'h00);
		chk(er, 1'b0);
		$display("test unmapped done");
		// Pins stay high here, so a change of tx_on can only come from the register.
		apb(1'b1, IDX_TXEN, 8'h00);
		cyc(2);
		chk(clk_stop, 1'b1);
		chk(ctl[0].tx_on, 1'b0);
		chk(ctl[1].safe_code, 1'b1);
		apb(1'b1, IDX_TXEN, 8'h03);
		cyc(4);
		chk(clk_stop, 1'b0);
		chk(ctl[0].tx_on, 1'b0);
		valid <= 1'b1;
		cyc(4);
		chk(ctl[0].tx_on, 1'b1);
		chk(ctl[1].tx_on, 1'b1);
		chk(ctl[1].safe_code, 1'b0);
		$display("test clock stop done");
		want_b <= 1'b0;
		apb(1'b1, IDX_TXSEL, 8'h04);
		cyc(6);
		chk(ctl[0].tx_on, 1'b1);
		chk(ctl[1].tx_on, 1'b0);
		want_a <= 1'b0;
		cyc(2);
		chk(ctl[0].tx_on, 1'b1);
		cyc(6);
		chk(ctl[0].tx_on, 1'b0);
		chk(clk_stop, 1'b0);
		want_b <= 1'b1;
		cyc(4);
		chk(ctl[1].tx_on, 1'b0);
		cyc(1);
		chk(ctl[1].tx_on, 1'b1);
		apb(1'b1, IDX_TXSEL, 8'h07);
		apb(1'b1, IDX_TXEN, 8'h02);
		cyc(2);
		chk(ctl[0].tx_on, 1'b0);
		chk(ctl[1].tx_on, 1'b1);
		chk(clk_stop, 1'b0);
		$display("test pin source done");
		apb(1'b1, IDX_TXSEL, 8'h0c);
		cyc(4);
		chk(ctl[0].dem_mute, 1'b1);
		// With QUIET_LAT of 4 the enable shows seven edges after the pin moves.
		want_a <= 1'b1;
		cyc(8);
		chk(ctl[0].tx_on, 1'b0);
		cyc(1);
		chk(ctl[0].tx_on, 1'b1);
		chk(ctl[0].dem_mute, 1'b0);
		$display("test quiet done");
		apb(1'b1, IDX_CTRL, 8'h01);
		chk(datapath_enable, 1'b1);
		rst_n <= 1'b0;
		cyc(3);
		chk(ctl, 32'h0);
		rst_n <= 1'b1;
		cyc(3);
		chk(ctl[0].tx_on, 1'b1);
		chk(datapath_enable, 1'b0);
		chk(clk_stop, 1'b0);
		apb(1'b0, IDX_TXSEL, 8'h00);
		chk(rd, 32'h03);
		$display("test mid-run reset done");
		wrap_up();
	end
endmodule // tb_dacom_top

// File: verilog/dacom_pkg.sv
// Package with register map, field layout, format codes and channel carrier type.
package dacom_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register indices; byte address is four times the index.
	localparam logic [9:0] IDX_FORMAT = 10'h2e8;
	localparam logic [9:0] IDX_TRUNC  = 10'h2ea;
	localparam logic [9:0] IDX_CTRL   = 10'h2f0;
	localparam logic [9:0] IDX_STAT   = 10'h2f1;
	localparam logic [9:0] IDX_TXSEL  = 10'h2f8;
	localparam logic [9:0] IDX_TXEN   = 10'h2f9;

	////////////////////////////////////////////////////////////////////////////
	// Reset values.
	localparam logic [7:0] RST_FORMAT = 8'h00;
	localparam logic [7:0] RST_TRUNC  = 8'h00;
	localparam logic [7:0] RST_CTRL   = 8'h00;
	localparam logic [7:0] RST_TXSEL  = 8'h03;
	localparam logic [7:0] RST_TXEN   = 8'h03;

	////////////////////////////////////////////////////////////////////////////
	// Field positions.
	localparam int FMT_B_LSB   = 4;
	localparam int FMT_A_LSB   = 0;
	localparam int TRUNC_BIT   = 0;
	localparam int CTRL_DATAPATH_ENABLE  = 0;
	localparam int CTRL_NARROW = 1;
	localparam int SEL_QUIET   = 3;
	localparam int SEL_FAST    = 2;
	localparam int SEL_SRC_B   = 1;
	localparam int SEL_SRC_A   = 0;
	localparam int TXEN_B      = 1;
	localparam int TXEN_A      = 0;

	////////////////////////////////////////////////////////////////////////////
	// Pulse format codes.
	localparam logic [2:0] FMT_NRZ      = 3'h0;
	localparam logic [2:0] FMT_RTI      = 3'h1;
	localparam logic [2:0] FMT_RTZ      = 3'h2;
	localparam logic [2:0] FMT_LOWPASS  = 3'h3;
	localparam logic [2:0] FMT_HIGHPASS = 3'h4;
	localparam logic [2:0] FMT_DIRECT   = 3'h5;
	localparam logic [2:0] FMT_DISABLED = 3'h6;

	// Added enable-to-output latency of quiet disable, in converter clocks.
	localparam int QUIET_LAT_CLKS = 56;

	typedef struct packed {
		logic nrz;
		logic return_to_inverse;
		logic rtz;
		logic double_rate_lowpass;
		logic double_rate_highpass;
		logic double_rate_direct;
		logic disabled;
		logic half_lsb;
		logic tx_on;
		logic safe_code;
		logic dem_mute;
	} dacom_chan_t;

endpackage

// File: verilog/dacom_sync.sv
// Two-flop synchroniser for asynchronous pin levels.
`timescale 1ns/1ns
module dacom_sync #(
	parameter int W = 2
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= din;
			sync_q <= meta_q;
		end
	end

	assign dout = sync_q;
endmodule // dacom_sync

// File: verilog/dacom_top.sv
// Output pulse format and transmit enable control with APB register access.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
module dacom_top
	import dacom_pkg::*;
#(
	parameter int ADDR_W    = 12,
	parameter int QUIET_LAT = QUIET_LAT_CLKS
) (
	input  wire logic              REF_CLK,
	input  wire logic              RESET_N,
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [ADDR_W-1:0] PADDR,
	input  wire logic [31:0]       PWDATA,
	input  wire logic [3:0]        PSTRB,
	output logic      [31:0]       PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR,
	input  wire logic              CHAN_A_ENABLE_PIN,
	input  wire logic              CHAN_B_ENABLE_PIN,
	input  wire logic              OUT_DATA_VALID,
	output dacom_chan_t [1:0]      CHAN_CTL,
	output logic                   CLK_STOP,
	output logic                   DP_ENABLE
);

	if (ADDR_W < 12) begin : g_addr_w_chk
		$error("ADDR_W must be at least 12");
	end
	if (QUIET_LAT < 2) begin : g_quiet_lat_chk
		$error("QUIET_LAT must be at least 2");
	end

	typedef enum logic [1:0] {PWR_RUN, PWR_STOP, PWR_FILL} dacom_pwr_t;

	////////////////////////////////////////////////////////////////////////////
	// Registers and APB slave.
	logic [7:0]  format_q;
	logic [7:0]  trunc_q;
	logic [7:0]  ctrl_q;
	logic [7:0]  txsel_q;
	logic [7:0]  txen_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [7:0]  status;
	logic        setup;
	logic        wr_en;
	dacom_pwr_t  pwr_q;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
		return (a[ADDR_W-1:2] == {{(ADDR_W-12){1'b0}}, idx}) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return hit(a, IDX_FORMAT) || hit(a, IDX_TRUNC) || hit(a, IDX_CTRL) ||
			hit(a, IDX_STAT) || hit(a, IDX_TXSEL) || hit(a, IDX_TXEN);
	endfunction

	assign setup = PSEL && !PENABLE;
	assign wr_en = PSEL && PENABLE && pready_q && PWRITE && PSTRB[0] && !pslverr_q;

	// The answer is prepared in the setup cycle so that all bus outputs are flops.
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup && !mapped(PADDR);
			if (setup && !PWRITE) begin
				if (hit(PADDR, IDX_FORMAT)) begin
					prdata_q <= {24'h00_0000, format_q};
				end else if (hit(PADDR, IDX_TRUNC)) begin
					prdata_q <= {24'h00_0000, trunc_q};
				end else if (hit(PADDR, IDX_CTRL)) begin
					prdata_q <= {24'h00_0000, ctrl_q};
				end else if (hit(PADDR, IDX_STAT)) begin
					prdata_q <= {24'h00_0000, status};
				end else if (hit(PADDR, IDX_TXSEL)) begin
					prdata_q <= {24'h00_0000, txsel_q};
				end else if (hit(PADDR, IDX_TXEN)) begin
					prdata_q <= {24'h00_0000, txen_q};
				end else begin
					prdata_q <= 32'h0000_0000;
				end
			end else begin
				prdata_q <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			format_q <= RST_FORMAT;
			trunc_q  <= RST_TRUNC;
			ctrl_q   <= RST_CTRL;
			txsel_q  <= RST_TXSEL;
			txen_q   <= RST_TXEN;
		end else if (wr_en) begin
			if (hit(PADDR, IDX_FORMAT)) begin
				format_q <= PWDATA[7:0];
			end else if (hit(PADDR, IDX_TRUNC)) begin
				trunc_q <= PWDATA[7:0];
			end else if (hit(PADDR, IDX_CTRL)) begin
				ctrl_q <= PWDATA[7:0];
			end else if (hit(PADDR, IDX_TXSEL)) begin
				txsel_q <= PWDATA[7:0];
			end else if (hit(PADDR, IDX_TXEN)) begin
				txen_q <= PWDATA[7:0];
			end
		end
	end

	assign PRDATA  = prdata_q;
	assign PREADY  = pready_q;
	assign PSLVERR = pslverr_q;

	////////////////////////////////////////////////////////////////////////////
	// Transmit enable source selection.
	logic [1:0] pin_sync;
	logic [1:0] pin_raw;
	logic [1:0] src;
	logic [1:0] reg_en;
	logic [1:0] sel_en;
	logic [1:0] eff_en;
	logic       fast;
	logic       quiet_eff;

	assign pin_raw = {CHAN_B_ENABLE_PIN, CHAN_A_ENABLE_PIN};

	dacom_sync #(.W(2)) u_pin_sync (
		.clk   (REF_CLK),
		.rst_n (RESET_N),
		.din   (pin_raw),
		.dout  (pin_sync)
	);

	assign src    = {txsel_q[SEL_SRC_B], txsel_q[SEL_SRC_A]};
	assign reg_en = {txen_q[TXEN_B], txen_q[TXEN_A]};
	assign fast   = txsel_q[SEL_FAST];
	// Quiet disable is honoured only with fast enable, as software is told to keep.
	assign quiet_eff = txsel_q[SEL_QUIET] && fast;

	assign sel_en[1] = src[1] ? reg_en[1] : pin_sync[1];
	assign sel_en[0] = src[0] ? reg_en[0] : pin_sync[0];
	// Without fast enable the channels share one combined enable.
	assign eff_en = fast ? sel_en : {2{|sel_en}};

	////////////////////////////////////////////////////////////////////////////
	// Power saving: clock stop and mute until valid data reaches the output.
	logic clk_stop_q;

	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			pwr_q <= PWR_RUN;
		end else begin
			case (pwr_q)
				PWR_RUN: begin
					if (!fast && !(|sel_en)) begin
						pwr_q <= PWR_STOP;
					end
				end
				PWR_STOP: begin
					if (fast) begin
						pwr_q <= PWR_RUN;
					end else if (|sel_en) begin
						pwr_q <= PWR_FILL;
					end
				end
				PWR_FILL: begin
					if (fast || OUT_DATA_VALID) begin
						pwr_q <= PWR_RUN;
					end else if (!(|sel_en)) begin
						pwr_q <= PWR_STOP;
					end
				end
				default: begin
					pwr_q <= PWR_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			clk_stop_q <= 1'b0;
		end else begin
			clk_stop_q <= !fast && (pwr_q == PWR_STOP) && !(|sel_en);
		end
	end

	assign CLK_STOP  = clk_stop_q;
	assign DP_ENABLE = ctrl_q[CTRL_DATAPATH_ENABLE];

	assign status = {2'h0, pin_sync, (pwr_q == PWR_FILL), clk_stop_q, eff_en};

	////////////////////////////////////////////////////////////////////////////
	// Per-channel format decode and enable timing.
	function automatic dacom_chan_t decode(input logic [2:0] code);
		dacom_chan_t c;
		c = '0;
		case (code)
			FMT_NRZ:      c.nrz = 1'b1;
			FMT_RTI:      c.return_to_inverse = 1'b1;
			FMT_RTZ:      c.rtz = 1'b1;
			FMT_LOWPASS:  c.double_rate_lowpass = 1'b1;
			FMT_HIGHPASS: c.double_rate_highpass = 1'b1;
			FMT_DIRECT:   c.double_rate_direct = 1'b1;
			default:      c.disabled = 1'b1;
		endcase
		return c;
	endfunction

	logic [2:0]  fmt_code [2];
	dacom_chan_t chan_q   [2];
	logic        half_lsb;

	assign fmt_code[1] = format_q[FMT_B_LSB +: 3];
	assign fmt_code[0] = format_q[FMT_A_LSB +: 3];
	assign half_lsb    = trunc_q[TRUNC_BIT] && ctrl_q[CTRL_NARROW];

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_chan
			logic [QUIET_LAT-1:0] line_q;
			logic                 run;
			dacom_chan_t          nxt;

			assign run = eff_en[ch] && (pwr_q == PWR_RUN);

			// Enable history used to delay the quiet path by the muting latency.
			always_ff @(posedge REF_CLK) begin
				if (!RESET_N) begin
					line_q <= '0;
				end else begin
					line_q <= {line_q[QUIET_LAT-2:0], run};
				end
			end

			always_comb begin
				nxt          = decode(fmt_code[ch]);
				nxt.half_lsb = half_lsb;
				if (quiet_eff) begin
					nxt.tx_on     = line_q[QUIET_LAT-1] && run;
					nxt.dem_mute  = !run;
					nxt.safe_code = 1'b0;
				end else begin
					nxt.tx_on     = run;
					nxt.dem_mute  = 1'b0;
					nxt.safe_code = !run;
				end
			end

			always_ff @(posedge REF_CLK) begin
				if (!RESET_N) begin
					chan_q[ch] <= '0;
				end else begin
					chan_q[ch] <= nxt;
				end
			end

			assign CHAN_CTL[ch] = chan_q[ch];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);

	chk_fmt_b_rtz: assert property (
		(format_q[6:4] == 3'h2) |=> CHAN_CTL[1].rtz && !CHAN_CTL[1].nrz)
		else $error("channel B code 2 did not give return-to-zero");
	chk_fmt_a_rti: assert property (
		(format_q[2:0] == 3'h1) |=> CHAN_CTL[0].return_to_inverse)
		else $error("channel A code 1 did not give return-to-inverse");
	chk_fmt_interp: assert property (
		(format_q[2:0] == 3'h4) && (format_q[6:4] == 3'h3) |=>
		CHAN_CTL[0].double_rate_highpass && CHAN_CTL[1].double_rate_lowpass)
		else $error("interpolator modes decoded wrongly");
	chk_fmt_direct_off: assert property (
		(format_q[2:0] == 3'h5) && (format_q[6:4] >= 3'h6) |=>
		CHAN_CTL[0].double_rate_direct && CHAN_CTL[1].disabled)
		else $error("direct or disabled code decoded wrongly");
	chk_half_lsb: assert property (
		trunc_q[TRUNC_BIT] && ctrl_q[CTRL_NARROW] |=>
		CHAN_CTL[0].half_lsb && CHAN_CTL[1].half_lsb)
		else $error("half-LSB offset not applied");
	chk_quiet_latency: assert property (
		quiet_eff && g_chan[0].run && $past(g_chan[0].run, QUIET_LAT) |=> CHAN_CTL[0].tx_on)
		else $error("quiet path enable did not arrive after the muting latency");
	chk_quiet_early: assert property (
		quiet_eff && !$past(g_chan[0].run, QUIET_LAT) |=> !CHAN_CTL[0].tx_on)
		else $error("quiet path enable arrived before the muting latency");
	chk_safe_code: assert property (
		!quiet_eff && fast && !eff_en[1] |=> CHAN_CTL[1].safe_code && !CHAN_CTL[1].tx_on)
		else $error("safe code not sent on disabled channel");
	chk_clock_stop: assert property (
		(!fast && !(|sel_en)) [*3] |=> CLK_STOP ##1 (CLK_STOP || |sel_en || fast))
		else $error("clocks not stopped with both enables low");
	chk_fill_mute: assert property (
		pwr_q == PWR_FILL && !OUT_DATA_VALID |=> !CHAN_CTL[0].tx_on && !CHAN_CTL[1].tx_on)
		else $error("output not muted while waiting for valid data");
	chk_reg_source: assert property (
		fast && !quiet_eff && src[0] && !reg_en[0] && pwr_q == PWR_RUN |=> !CHAN_CTL[0].tx_on)
		else $error("register enable bit ignored");
	chk_pin_sync: assert property (
		fast && !quiet_eff && !src[1] && $rose(CHAN_B_ENABLE_PIN) && !CHAN_CTL[1].tx_on
		&& !pin_sync[1] |=> !CHAN_CTL[1].tx_on)
		else $error("enable pin acted without synchroniser delay");
	chk_unmapped: assert property (
		setup && !mapped(PADDR) |=> PREADY && PSLVERR)
		else $error("unmapped address not refused");

endmodule // dacom_top
